// File: core/wss_pkg.sv
// constants and types shared by the supervisor files
package wss_pkg;
	// ****************************************
	// register addresses and layouts
	// ****************************************
	localparam logic [7:0] WSS_ADDR_WDOG_CTRL   = 8'hc0;
	localparam logic [7:0] WSS_ADDR_SUPPLY_CTRL = 8'hdf;
	localparam logic [7:0] WSS_RST_WDOG_CTRL    = 8'h00;
	localparam logic [7:0] WSS_RST_SUPPLY_CTRL  = 8'hdc;
	localparam int WSS_WD_PRE_HI    = 7;
	localparam int WSS_WD_PRE_LO    = 5;
	localparam int WSS_WD_R1_BIT    = 3;
	localparam int WSS_WD_R2_BIT    = 2;
	localparam int WSS_WD_FLAG_BIT  = 1;
	localparam int WSS_WD_EN_BIT    = 0;
	localparam int WSS_SM_CMP_BIT   = 6;
	localparam int WSS_SM_IRQ_BIT   = 5;
	localparam int WSS_SM_TP_HI     = 4;
	localparam int WSS_SM_TP_LO     = 2;
	localparam int WSS_SM_SRC_BIT   = 1;
	localparam int WSS_SM_EN_BIT    = 0;
	localparam int WSS_SM_SPARE_BIT = 7;
	localparam int WSS_IE2_SM_BIT   = 1;
	// ****************************************
	// timing
	// ****************************************
	localparam int WSS_CLK_HZ       = 50_000_000;
	localparam int WSS_TICK_US      = 1000;
	localparam int WSS_TICK_CYCLES  = WSS_CLK_HZ / 1_000_000 * WSS_TICK_US;
	localparam int WSS_WD_BASE_MS   = 16;
	localparam int WSS_HOLD_MS      = 256;
	localparam int WSS_FILT_CYCLES  = 8;
	localparam int WSS_WD_WIDTH     = 16;
	localparam logic [3:0] WSS_RST_PULSE = 4'hf;
	// ****************************************
	// refresh sequence states, gray coded
	// ****************************************
	typedef enum logic [1:0] {
		WSS_RF_IDLE  = 2'b00,
		WSS_RF_ARMED = 2'b01
	} wss_refresh_t;
endpackage

// File: core/wss_sfr_if.sv
// special function register port shared by the supervisor and its monitor
`timescale 1ns/1ps
interface wss_sfr_if;
	logic       wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport core (output wr, output addr, output wdata, input rdata);
	modport dev  (input wr, input addr, input wdata, output rdata);
endinterface

// File: core/wss_supply_mon.sv
// supply monitor: filter, interrupt flag, hold-off timer, trip select
`timescale 1ns/1ps
module wss_supply_mon
	import wss_pkg::*;
#(
	parameter int HOLD_MS = WSS_HOLD_MS
)(
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_rstn,
	// register port
	wss_sfr_if.dev    sfr,
	// synchronised comparators and tick
	input  wire logic i_avdd_ok,
	input  wire logic i_dvdd_ok,
	input  wire logic i_tick,
	// outputs
	output logic      o_irq_flag,
	output logic      o_enable,
	output logic [2:0] o_trip_sel
);
	logic [3:0]  filt_cnt_reg;
	logic        cmp_reg;
	logic        src_reg;
	logic        irq_reg;
	logic [2:0]  tp_reg;
	logic        en_reg;
	logic [15:0] hold_reg;
	logic        raw_ok;
	logic        wr_hit;
	assign raw_ok = i_avdd_ok & i_dvdd_ok;
	assign wr_hit = sfr.wr && sfr.addr == WSS_ADDR_SUPPLY_CTRL;
	// ****************************************
	// glitch filter: a low must persist before it counts
	// ****************************************
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn || !en_reg)
		begin
			filt_cnt_reg <= 4'h0;
			cmp_reg      <= 1'b1;
		end
		else if (raw_ok)
		begin
			filt_cnt_reg <= 4'h0;
			cmp_reg      <= 1'b1;
		end
		else if (filt_cnt_reg == 4'(WSS_FILT_CYCLES - 1))
			cmp_reg <= 1'b0;
		else
			filt_cnt_reg <= filt_cnt_reg + 4'h1;
	end
	// ****************************************
	// interrupt flag, source, hold-off
	// ****************************************
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			irq_reg  <= WSS_RST_SUPPLY_CTRL[WSS_SM_IRQ_BIT];
			src_reg  <= WSS_RST_SUPPLY_CTRL[WSS_SM_SRC_BIT];
			hold_reg <= 16'h0000;
		end
		else if (!cmp_reg)
		begin
			irq_reg  <= 1'b1;
			// only a supply that is low now can name the fault, so recovery keeps it
			if (!raw_ok)
				src_reg <= !i_avdd_ok;
			hold_reg <= 16'h0000;
		end
		else if (wr_hit)
		begin
			irq_reg  <= sfr.wdata[WSS_SM_IRQ_BIT];
			hold_reg <= 16'h0000;
		end
		else if (irq_reg && i_tick)
		begin
			if (hold_reg == 16'(HOLD_MS - 1))
			begin
				irq_reg  <= 1'b0;
				hold_reg <= 16'h0000;
			end
			else
				hold_reg <= hold_reg + 16'h0001;
		end
	end
	// ****************************************
	// control fields
	// ****************************************
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			tp_reg <= WSS_RST_SUPPLY_CTRL[WSS_SM_TP_HI:WSS_SM_TP_LO];
			en_reg <= WSS_RST_SUPPLY_CTRL[WSS_SM_EN_BIT];
		end
		else if (wr_hit)
		begin
			tp_reg <= sfr.wdata[WSS_SM_TP_HI:WSS_SM_TP_LO];
			en_reg <= sfr.wdata[WSS_SM_EN_BIT];
		end
	end
	// spare bit reads its reset value so the whole byte matches after reset
	assign sfr.rdata  = {WSS_RST_SUPPLY_CTRL[WSS_SM_SPARE_BIT], cmp_reg, irq_reg, tp_reg, src_reg, en_reg};
	assign o_irq_flag = irq_reg;
	assign o_enable   = en_reg;
	assign o_trip_sel = tp_reg;
	// ****************************************
	// checks
	// ****************************************
	chk_clear_refused: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!cmp_reg |=> irq_reg)
		else $error("supply flag cleared while comparator low");
	chk_filter_short: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(en_reg && cmp_reg && raw_ok) ##1 !raw_ok[*4] ##1 raw_ok |=> cmp_reg)
		else $error("short glitch reached the flag");
endmodule

// File: core/wss_supervisor.sv
// watchdog and supply supervisor top
`timescale 1ns/1ps
// Function
// - enabled watchdog resets the system when refresh is missed before timeout
// - clearing the enable bit stops the watchdog entirely
// - the watchdog counter is sixteen bits wide
// - prescale bits 7..5 pick timeout 16 ms doubling up to 2048 ms
// - a timeout sets the watchdog status flag
// - status flag clears by software zero or external reset, not watchdog reset
// - turning the watchdog on clears its counters
// - bit 6 reads one when both supplies are above trip point
// - supply interrupt flag sets while combined comparator status is low
// - flag clears after supplies stay good for 256 ms; lows restart timing
// - software cannot clear supply flag while a comparator is low
// - supply flag interrupts only when its enable bit is set
// - bits 4..2 select supply trip threshold
// - bit 1 reads one when analog supply caused the fault
// - bit 0 turns the supply monitor on or off
// - comparator inputs are filtered against short glitches
module wss_supervisor
	import wss_pkg::*;
#(
	parameter int TICK_CYCLES = WSS_TICK_CYCLES,
	parameter int HOLD_MS     = WSS_HOLD_MS
)(
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_rstn,
	// special function register port
	input  wire logic       i_sfr_wr,
	input  wire logic       i_sfr_rd,
	input  wire logic [7:0] i_sfr_addr,
	input  wire logic [7:0] i_sfr_wdata,
	output logic      [7:0] o_sfr_rdata,
	// interrupt enable register bits
	input  wire logic [7:0] i_irq_enable,
	// comparator pins
	input  wire logic       i_avdd_cmp,
	input  wire logic       i_dvdd_cmp,
	// outputs
	output logic            o_sys_reset,
	output logic            o_supply_irq,
	output logic            o_monitor_enable,
	output logic [2:0]      o_trip_select
);
	wss_sfr_if sfr_sm ();
	logic [2:0]  pre_reg;
	logic        r1_reg;
	logic        r2_reg;
	logic        flag_reg;
	logic        en_reg;
	logic [WSS_WD_WIDTH-1:0] cnt_reg;
	logic [31:0] div_reg;
	logic        tick_reg;
	logic [3:0]  rst_cnt_reg;
	logic [1:0]  av_sync_reg;
	logic [1:0]  dv_sync_reg;
	logic        sm_flag;
	logic        sm_en;
	logic [2:0]  sm_tp;
	logic        wd_hit;
	logic        timeout;
	logic        refresh_done;
	logic        wd_reset;
	logic [WSS_WD_WIDTH-1:0] limit;
	wss_refresh_t rf_reg;
	wss_refresh_t rf_next;
	assign wd_hit = i_sfr_wr && i_sfr_addr == WSS_ADDR_WDOG_CTRL;
	assign limit  = WSS_WD_WIDTH'(WSS_WD_BASE_MS) << pre_reg;
	// ****************************************
	// input synchronisers
	// ****************************************
	// comparators are asynchronous; only the second stage is read
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			av_sync_reg <= 2'h3;
			dv_sync_reg <= 2'h3;
		end
		else
		begin
			av_sync_reg <= {av_sync_reg[0], i_avdd_cmp};
			dv_sync_reg <= {dv_sync_reg[0], i_dvdd_cmp};
		end
	end
	// ****************************************
	// millisecond time base
	// ****************************************
	// free running and shared with the hold-off; enabling does not realign it, so the first tick may come early
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn || div_reg == 32'(TICK_CYCLES - 1))
			div_reg <= 32'h0000_0000;
		else
			div_reg <= div_reg + 32'h0000_0001;
	end
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
			tick_reg <= 1'b0;
		else
			tick_reg <= div_reg == 32'(TICK_CYCLES - 1);
	end
	// ****************************************
	// refresh sequence
	// ****************************************
	// a write that drops the first bit without the second disarms, so a stray second-bit write never refreshes
	always_comb
	begin
		rf_next      = rf_reg;
		refresh_done = 1'b0;
		case (rf_reg)
			WSS_RF_IDLE:
				if (wd_hit && i_sfr_wdata[WSS_WD_R1_BIT] && !i_sfr_wdata[WSS_WD_R2_BIT])
					rf_next = WSS_RF_ARMED;
			WSS_RF_ARMED:
				if (wd_hit && i_sfr_wdata[WSS_WD_R2_BIT])
				begin
					refresh_done = 1'b1;
					rf_next      = WSS_RF_IDLE;
				end
				else if (wd_hit && !i_sfr_wdata[WSS_WD_R1_BIT])
					rf_next = WSS_RF_IDLE;
			default:
				rf_next = WSS_RF_IDLE;
		endcase
	end
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn || !en_reg)
			rf_reg <= WSS_RF_IDLE;
		else
			rf_reg <= rf_next;
	end
	// ****************************************
	// watchdog control register
	// ****************************************
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			pre_reg <= WSS_RST_WDOG_CTRL[WSS_WD_PRE_HI:WSS_WD_PRE_LO];
			en_reg  <= WSS_RST_WDOG_CTRL[WSS_WD_EN_BIT];
			r1_reg  <= 1'b0;
			r2_reg  <= 1'b0;
		end
		else if (wd_hit)
		begin
			pre_reg <= i_sfr_wdata[WSS_WD_PRE_HI:WSS_WD_PRE_LO];
			en_reg  <= i_sfr_wdata[WSS_WD_EN_BIT];
			r1_reg  <= i_sfr_wdata[WSS_WD_R1_BIT] && !refresh_done;
			r2_reg  <= 1'b0;
		end
	end
	// flag stays put through a watchdog reset; only i_rstn or a zero write clears it
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
			flag_reg <= WSS_RST_WDOG_CTRL[WSS_WD_FLAG_BIT];
		else if (timeout)
			flag_reg <= 1'b1;
		else if (wd_hit && !i_sfr_wdata[WSS_WD_FLAG_BIT])
			flag_reg <= 1'b0;
	end
	// ****************************************
	// watchdog counter, ms units
	// ****************************************
	// held at zero while disabled, so turning the watchdog on always starts the count from zero
	assign timeout = en_reg && tick_reg && (cnt_reg == limit - 1'b1);
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn || !en_reg || refresh_done || timeout)
			cnt_reg <= '0;
		else if (wd_hit && i_sfr_wdata[WSS_WD_EN_BIT] && !en_reg)
			cnt_reg <= '0;
		else if (tick_reg)
			cnt_reg <= cnt_reg + 1'b1;
	end
	// ****************************************
	// system reset pulse
	// ****************************************
	// fixed length so the wider system sees a clean reset; only a new timeout reloads it
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
			rst_cnt_reg <= 4'h0;
		else if (timeout)
			rst_cnt_reg <= WSS_RST_PULSE;
		else if (rst_cnt_reg != 4'h0)
			rst_cnt_reg <= rst_cnt_reg - 4'h1;
	end
	assign wd_reset = rst_cnt_reg != 4'h0;
	// ****************************************
	// supply monitor
	// ****************************************
	assign sfr_sm.wr    = i_sfr_wr;
	assign sfr_sm.addr  = i_sfr_addr;
	assign sfr_sm.wdata = i_sfr_wdata;
	wss_supply_mon #(
		.HOLD_MS (HOLD_MS)
	) u_supply (
		.i_clock    (i_clock),
		.i_rstn     (i_rstn),
		.sfr        (sfr_sm),
		.i_avdd_ok  (av_sync_reg[1]),
		.i_dvdd_ok  (dv_sync_reg[1]),
		.i_tick     (tick_reg),
		.o_irq_flag (sm_flag),
		.o_enable   (sm_en),
		.o_trip_sel (sm_tp)
	);
	// ****************************************
	// registered outputs
	// ****************************************
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			o_sys_reset      <= 1'b0;
			o_supply_irq     <= 1'b0;
			o_monitor_enable <= WSS_RST_SUPPLY_CTRL[WSS_SM_EN_BIT];
			o_trip_select    <= WSS_RST_SUPPLY_CTRL[WSS_SM_TP_HI:WSS_SM_TP_LO];
			o_sfr_rdata      <= 8'h00;
		end
		else
		begin
			o_sys_reset      <= wd_reset;
			o_supply_irq     <= sm_flag && i_irq_enable[WSS_IE2_SM_BIT];
			o_monitor_enable <= sm_en;
			o_trip_select    <= sm_tp;
			if (i_sfr_rd && i_sfr_addr == WSS_ADDR_WDOG_CTRL)
				o_sfr_rdata <= {pre_reg, 1'b0, r1_reg, r2_reg, flag_reg, en_reg};
			else if (i_sfr_rd && i_sfr_addr == WSS_ADDR_SUPPLY_CTRL)
				o_sfr_rdata <= sfr_sm.rdata;
			else
				o_sfr_rdata <= 8'h00;
		end
	end
	// ****************************************
	// checks
	// ****************************************
	sequence s_refresh_pair;
		(wd_hit && rf_reg == WSS_RF_ARMED && i_sfr_wdata[WSS_WD_R2_BIT]);
	endsequence
	sequence s_arm_write;
		(wd_hit && i_sfr_wdata[WSS_WD_R1_BIT] && !i_sfr_wdata[WSS_WD_R2_BIT]);
	endsequence
	sequence s_lone_second;
		(wd_hit && rf_reg == WSS_RF_IDLE && i_sfr_wdata[WSS_WD_R2_BIT]);
	endsequence
	chk_timeout_reset: assert property (@(posedge i_clock) disable iff (!i_rstn)
		timeout |=> wd_reset ##1 o_sys_reset)
		else $error("timeout did not raise system reset");
	chk_disabled_quiet: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!en_reg && !wd_reset |=> !wd_reset)
		else $error("timeout while watchdog disabled");
	chk_refresh_restart: assert property (@(posedge i_clock) disable iff (!i_rstn)
		s_refresh_pair |=> cnt_reg == '0)
		else $error("refresh did not restart counter");
	chk_flag_set: assert property (@(posedge i_clock) disable iff (!i_rstn)
		timeout |=> flag_reg)
		else $error("timeout did not set status flag");
	chk_flag_sticky: assert property (@(posedge i_clock) disable iff (!i_rstn)
		flag_reg && !wd_hit |=> flag_reg)
		else $error("status flag cleared without a write");
	chk_enable_clear: assert property (@(posedge i_clock) disable iff (!i_rstn)
		wd_hit && i_sfr_wdata[WSS_WD_EN_BIT] && !en_reg |=> cnt_reg == '0)
		else $error("enable did not clear counter");
	chk_irq_gate: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!i_irq_enable[WSS_IE2_SM_BIT] |=> !o_supply_irq)
		else $error("supply irq without enable");
	chk_tick_spacing: assert property (@(posedge i_clock) disable iff (!i_rstn)
		tick_reg |=> !tick_reg)
		else $error("time base ticks back to back");
	// ****************************************
	// refresh, counter, flag, pulse, supply interrupt and read-back checks
	// ****************************************
	chk_arm_first: assert property (@(posedge i_clock) disable iff (!i_rstn)
		en_reg ##0 s_arm_write |=> rf_reg == WSS_RF_ARMED)
		else $error("first refresh bit did not arm");
	chk_lone_second: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(en_reg && !tick_reg) ##0 s_lone_second |=> cnt_reg == $past(cnt_reg))
		else $error("second bit alone restarted counter");
	chk_count_step: assert property (@(posedge i_clock) disable iff (!i_rstn)
		en_reg && tick_reg && !timeout && !refresh_done |=> cnt_reg == $past(cnt_reg) + 1'b1)
		else $error("watchdog counter missed a tick");
	chk_flag_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
		wd_hit && !i_sfr_wdata[WSS_WD_FLAG_BIT] && !timeout |=> !flag_reg)
		else $error("status flag ignored a zero write");
	chk_flag_read: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_sfr_rd && i_sfr_addr == WSS_ADDR_WDOG_CTRL |=> o_sfr_rdata[WSS_WD_FLAG_BIT] == $past(flag_reg))
		else $error("status flag read back wrong");
	chk_pulse_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
		$rose(o_sys_reset) |-> o_sys_reset[*8])
		else $error("system reset pulse too short");
	chk_supply_irq_on: assert property (@(posedge i_clock) disable iff (!i_rstn)
		sm_flag && i_irq_enable[WSS_IE2_SM_BIT] |=> o_supply_irq)
		else $error("enabled supply flag did not interrupt");
	chk_supply_read: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_sfr_rd && i_sfr_addr == WSS_ADDR_SUPPLY_CTRL |=> o_sfr_rdata == $past(sfr_sm.rdata))
		else $error("supply register read back wrong");
endmodule

// File: test/wss_core_model.sv
// behavioural processor core that reaches the supervisor registers
`timescale 1ns/1ps
module wss_core_model
	import wss_pkg::*;
(
	// clock
	input  wire logic       i_clock,
	// register port
	output logic            o_sfr_wr,
	output logic            o_sfr_rd,
	output logic      [7:0] o_sfr_addr,
	output logic      [7:0] o_sfr_wdata,
	input  wire logic [7:0] i_sfr_rdata
);
	initial
	begin
		o_sfr_wr = 1'b0;
		o_sfr_rd = 1'b0;
		o_sfr_addr = 8'h00;
		o_sfr_wdata = 8'h00;
	end
	// ****************************************
	// bus cycles
	// ****************************************
	// idle lines show the inverse of the last value, so stale data never passes
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge i_clock);
		o_sfr_wr = 1'b1;
		o_sfr_addr = addr;
		o_sfr_wdata = data;
		@(negedge i_clock);
		o_sfr_wr = 1'b0;
		o_sfr_addr = ~addr;
		o_sfr_wdata = ~data;
	endtask
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(negedge i_clock);
		o_sfr_rd = 1'b1;
		o_sfr_addr = addr;
		@(negedge i_clock);
		data = i_sfr_rdata;
		o_sfr_rd = 1'b0;
		o_sfr_addr = ~addr;
	endtask
	// first refresh bit, then second, with the idle cycle between the writes
	task automatic refresh(input logic [7:0] ctrl);
		write_reg(WSS_ADDR_WDOG_CTRL, (ctrl & 8'hf3) | 8'h08);
		write_reg(WSS_ADDR_WDOG_CTRL, (ctrl & 8'hf3) | 8'h0c);
	endtask
endmodule

// File: test/wss_supervisor_test.sv
// self-checking bench for the watchdog and supply supervisor
`timescale 1ns/1ps
module wss_supervisor_test
	import wss_pkg::*;
;
	// ****************************************
	// signals
	// ****************************************
	// short tick keeps the longest timeout near twenty thousand cycles
	localparam int TICK = 10;
	localparam int HOLD = WSS_HOLD_MS;
	logic       i_clock;
	logic       i_rstn;
	logic [7:0] i_irq_enable;
	logic       i_avdd_cmp;
	logic       i_dvdd_cmp;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic       sys_reset;
	logic       supply_irq;
	logic       mon_en;
	logic [2:0] trip_sel;
	logic [7:0] rd;
	logic [2:0] tp;
	logic       saw;
	int         n;
	int         seed;
	int         mismatches;
	int         n_checks;
	initial i_clock = 1'b0;
	always #10 i_clock = ~i_clock;
	wss_core_model core (
		.i_clock    (i_clock),
		.o_sfr_wr   (sfr_wr),
		.o_sfr_rd   (sfr_rd),
		.o_sfr_addr (sfr_addr),
		.o_sfr_wdata(sfr_wdata),
		.i_sfr_rdata(sfr_rdata)
	);
	wss_supervisor #(.TICK_CYCLES(TICK), .HOLD_MS(HOLD)) dut (
		.i_clock         (i_clock),
		.i_rstn          (i_rstn),
		.i_sfr_wr        (sfr_wr),
		.i_sfr_rd        (sfr_rd),
		.i_sfr_addr      (sfr_addr),
		.i_sfr_wdata     (sfr_wdata),
		.o_sfr_rdata     (sfr_rdata),
		.i_irq_enable    (i_irq_enable),
		.i_avdd_cmp      (i_avdd_cmp),
		.i_dvdd_cmp      (i_dvdd_cmp),
		.o_sys_reset     (sys_reset),
		.o_supply_irq    (supply_irq),
		.o_monitor_enable(mon_en),
		.o_trip_select   (trip_sel)
	);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] sm_exp(logic c, logic f, logic [2:0] t, logic s, logic e);
		return {1'b0, c, f, t, s, e};
	endfunction
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic check_range(input int got, input int lo, input int hi, input string what);
		n_checks++;
		if (got < lo || got > hi)
		begin
			mismatches++;
			$display("[FAIL] %0t %s took %0d not %0d..%0d", $time, what, got, lo, hi);
		end
	endtask
	// bounded wait for a level; running out ends the run
	task automatic wait_for(ref logic sig, input logic lvl, input int bound, output int cyc);
		cyc = 0;
		while (sig !== lvl)
		begin
			@(negedge i_clock);
			cyc++;
			if (cyc > bound)
			begin
				mismatches++;
				$display("[FAIL] %0t wait ran out", $time);
				finish_test();
			end
		end
	endtask
	task automatic quiet(input int cyc, inout logic seen);
		repeat (cyc)
		begin
			@(negedge i_clock);
			if (sys_reset !== 1'b0)
				seen = 1'b1;
		end
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial
	begin
		seed = $urandom(32'h59895032);
		mismatches = 0;
		n_checks = 0;
		i_rstn = 1'b0;
		i_irq_enable = 8'h00;
		i_avdd_cmp = 1'b1;
		i_dvdd_cmp = 1'b1;
		repeat (4) @(negedge i_clock);
		i_rstn = 1'b1;
		core.read_reg(WSS_ADDR_WDOG_CTRL, rd);
		check_val(rd, WSS_RST_WDOG_CTRL, "wdog rst");
		core.read_reg(WSS_ADDR_SUPPLY_CTRL, rd);
		check_val(rd, WSS_RST_SUPPLY_CTRL, "supply rst");
		core.read_reg(8'h55, rd);
		check_val(rd, 8'h00, "unmapped");
		check_val({4'h0, trip_sel, mon_en}, 8'h0e, "outputs rst");
		$display("test reset done");
		for (int p = 0; p < 8; p++)
		begin
			core.write_reg(WSS_ADDR_WDOG_CTRL, {p[2:0], 5'h01});
			wait_for(sys_reset, 1'b1, (16 << p) * TICK + 50, n);
			check_range(n, ((16 << p) - 1) * TICK, (16 << p) * TICK + 8, "timeout");
			wait_for(sys_reset, 1'b0, 40, n);
			check_range(n, 15, 15, "pulse");
			core.read_reg(WSS_ADDR_WDOG_CTRL, rd);
			check_val(rd, {p[2:0], 5'h03}, "flag kept");
			core.write_reg(WSS_ADDR_WDOG_CTRL, 8'h00);
			core.read_reg(WSS_ADDR_WDOG_CTRL, rd);
			check_val(rd, 8'h00, "flag cleared");
		end
		$display("test prescale done");
		saw = 1'b0;
		core.write_reg(WSS_ADDR_WDOG_CTRL, 8'h01);
		quiet(120, saw);
		core.write_reg(WSS_ADDR_WDOG_CTRL, 8'h00);
		quiet(400, saw);
		check_val({7'h00, saw}, 8'h00, "disabled");
		core.write_reg(WSS_ADDR_WDOG_CTRL, 8'h01);
		wait_for(sys_reset, 1'b1, 400, n);
		check_range(n, 15 * TICK, 16 * TICK + 8, "enable clears");
		wait_for(sys_reset, 1'b0, 40, n);
		core.write_reg(WSS_ADDR_WDOG_CTRL, 8'h01);
		for (int k = 0; k < 6; k++)
		begin
			quiet(60 + $urandom_range(60), saw);
			core.refresh(8'h01);
		end
		check_val({7'h00, saw}, 8'h00, "refreshed");
		quiet(80, saw);
		core.write_reg(WSS_ADDR_WDOG_CTRL, 8'h05);
		wait_for(sys_reset, 1'b1, 400, n);
		check_range(n + 82, 15 * TICK, 16 * TICK + 8, "lone second bit");
		wait_for(sys_reset, 1'b0, 40, n);
		core.write_reg(WSS_ADDR_WDOG_CTRL, 8'h00);
		$display("test refresh done");
		tp = 3'($urandom_range(4));
		i_irq_enable = 8'($urandom) | 8'h02;
		core.write_reg(WSS_ADDR_SUPPLY_CTRL, {3'b000, tp, 2'b01});
		repeat (2) @(negedge i_clock);
		check_val({4'h0, trip_sel, mon_en}, {4'h0, tp, 1'b1}, "trip");
		check_val({7'h00, supply_irq}, 8'h00, "irq idle");
		i_avdd_cmp = 1'b0;
		repeat (4) @(negedge i_clock);
		i_avdd_cmp = 1'b1;
		repeat (12) @(negedge i_clock);
		core.read_reg(WSS_ADDR_SUPPLY_CTRL, rd);
		check_val(rd & 8'h7f, sm_exp(1, 0, tp, 0, 1), "glitch");
		i_avdd_cmp = 1'b0;
		repeat (16) @(negedge i_clock);
		core.read_reg(WSS_ADDR_SUPPLY_CTRL, rd);
		check_val(rd & 8'h7f, sm_exp(0, 1, tp, 1, 1), "avdd low");
		check_val({7'h00, supply_irq}, 8'h01, "irq on");
		core.write_reg(WSS_ADDR_SUPPLY_CTRL, {3'b000, tp, 2'b01});
		core.read_reg(WSS_ADDR_SUPPLY_CTRL, rd);
		check_val(rd & 8'h7f, sm_exp(0, 1, tp, 1, 1), "clear refused");
		i_irq_enable = i_irq_enable & 8'hfd;
		repeat (2) @(negedge i_clock);
		check_val({7'h00, supply_irq}, 8'h00, "irq masked");
		i_irq_enable = i_irq_enable | 8'h02;
		i_avdd_cmp = 1'b1;
		repeat (1000) @(negedge i_clock);
		i_avdd_cmp = 1'b0;
		repeat (16) @(negedge i_clock);
		i_avdd_cmp = 1'b1;
		wait_for(supply_irq, 1'b0, HOLD * TICK + 200, n);
		check_range(n, (HOLD - 1) * TICK, (HOLD + 1) * TICK + 30, "hold off");
		core.read_reg(WSS_ADDR_SUPPLY_CTRL, rd);
		check_val(rd & 8'h7f, sm_exp(1, 0, tp, 1, 1), "source kept");
		i_dvdd_cmp = 1'b0;
		repeat (16) @(negedge i_clock);
		core.read_reg(WSS_ADDR_SUPPLY_CTRL, rd);
		check_val(rd & 8'h7f, sm_exp(0, 1, tp, 0, 1), "dvdd low");
		i_dvdd_cmp = 1'b1;
		repeat (20) @(negedge i_clock);
		core.write_reg(WSS_ADDR_SUPPLY_CTRL, {3'b000, tp, 2'b01});
		core.read_reg(WSS_ADDR_SUPPLY_CTRL, rd);
		check_val(rd & 8'h7f, sm_exp(1, 0, tp, 0, 1), "clear good");
		core.write_reg(WSS_ADDR_SUPPLY_CTRL, {3'b000, tp, 2'b00});
		i_avdd_cmp = 1'b0;
		repeat (16) @(negedge i_clock);
		core.read_reg(WSS_ADDR_SUPPLY_CTRL, rd);
		check_val(rd & 8'h7f, sm_exp(1, 0, tp, 0, 0), "monitor off");
		check_val({7'h00, mon_en}, 8'h00, "enable pin");
		i_avdd_cmp = 1'b1;
		$display("test supply done");
		finish_test();
	end
endmodule
